// [rtl/hmc_defs.svh]
// Offsets, field positions, reset values and timing for the monitor
// configuration and status registers.
// Assumes an 8-bit indexed register space and a 25 MHz clock.
`ifndef HMC_DEFS_SVH
`define HMC_DEFS_SVH

// Register offsets within the indexed space
`define HMC_OFS_MAKER_ID        8'h3E
`define HMC_OFS_STEP_VER        8'h3F
`define HMC_OFS_CONFIG          8'h40
`define HMC_OFS_STATUS1         8'h41

// Configuration fields
`define HMC_CFG_START_BIT       0
`define HMC_CFG_RSTPULSE_BIT    4
`define HMC_CFG_PINSEL_BIT      5
`define HMC_CFG_INIT_BIT        7
`define HMC_CFG_RESET_VAL       8'h08
`define HMC_CFG_WR_MASK         8'h31

// Status register 1 fields
`define HMC_ST1_RESET_VAL       8'h00
`define HMC_ST1_USED_MASK       8'h1F

// Identity values, arbitrary neutral choices
`define HMC_MAKER_ID_VAL        8'hA5
`define HMC_VERSION_VAL         4'h1
`define HMC_STEPPING_VAL        4'h0

// Reset pulse timing
`define HMC_CLK_HZ              25000000
`define HMC_RSTPULSE_MS         20
`define HMC_RSTPULSE_CYC        ((`HMC_CLK_HZ / 1000) * `HMC_RSTPULSE_MS)

`endif

// [rtl/hmc_pkg.sv]
// Types shared by the monitor configuration and status block.
// Assumes the constants of hmc_defs.svh.
package hmc_pkg;

    // Limit-crossing events from the comparison engine, one per channel
    typedef struct packed {
        logic ambient_temp;
        logic rail_5v;
        logic rail_3v3;
        logic core;
        logic rail_2v5;
    } hmc_limit_evt_t;

    // Host access strobes into the indexed register space
    typedef struct packed {
        logic       index_wr;
        logic       data_wr;
        logic       data_rd;
        logic [7:0] wdata;
    } hmc_host_req_t;

    // Reset-pulse sequencer states
    typedef enum logic [0:0] {
        HMC_PULSE_IDLE,
        HMC_PULSE_LOW
    } hmc_pulse_state_t;

endpackage : hmc_pkg

// [rtl/hmc_top.sv]
// Identification, configuration and first limit-status registers of a
// hardware monitor, reached through an 8-bit write-only index register.
// Assumes host strobes and limit events come from logic on the same clock;
// the main-supply power-on sense arrives asynchronously from a pin.
`timescale 1ns/10ps
`include "hmc_defs.svh"

// Behaviour
// - Index register selects target of data access
// - Read-only maker identification at 3E
// - 3F reports stepping low, version high
// - Start bit one runs scanning and checking
// - Start bit zero holds selected low-power mode
// - Reset bit drives reset low 20 ms, clears
// - Bit 5 selects 12 V or VID4 pin
// - Init bit restores config and status, reads zero
// - Status bits 0-3 flag rail limit crossings
// - Status bit 4 flags ambient temperature crossing
// - Status read-only, cleared on power-on and init
module hmc_top #(
    parameter int unsigned RSTPULSE_CYC = `HMC_RSTPULSE_CYC
) (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst,
    // Host register access
    input  wire hmc_pkg::hmc_host_req_t host_req,
    output logic [7:0]                  rd_data,
    output logic                        rd_valid,
    output logic                        reg_hit,
    // Main supply power-on reset sense, asynchronous
    input  wire logic                   main_supply_sense,
    // Limit events from the comparison engine
    input  wire hmc_pkg::hmc_limit_evt_t limit_evt,
    // Controls from other monitor registers
    input  wire logic                   reset_out_enable,
    input  wire logic                   low_power_mode_sel,
    // Monitor controls
    output logic                        monitor_run,
    output logic                        low_power_hold,
    output logic                        low_power_mode,
    output logic                        shared_pin_function_select,
    output logic                        init_pulse,
    // Reset output pin
    output logic                        reset_out_n
);

    localparam int unsigned CNT_W = 32;

    logic [7:0]                  index_r;
    logic [7:0]                  cfg_r;
    logic [7:0]                  status1_r;
    logic [7:0]                  rd_data_r;
    logic                        rd_valid_r;
    logic                        supply_meta_r;
    logic                        supply_sync_r;
    logic                        supply_prev_r;
    logic                        init_pulse_r;
    logic                        reset_out_n_r;
    logic [CNT_W-1:0]            pulse_cnt_r;
    hmc_pkg::hmc_pulse_state_t   pulse_state_r;

    logic                        cfg_sel;
    logic                        cfg_wr;
    logic                        init_req;
    logic                        supply_por;
    logic                        restore;
    logic                        pulse_start;
    logic                        pulse_done;
    logic [7:0]                  rd_mux;
    logic [7:0]                  status1_nxt;

    // Index register, write-only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            index_r <= 8'h00;
        end else if (host_req.index_wr) begin
            index_r <= host_req.wdata;
        end
    end

    assign cfg_sel  = (index_r == `HMC_OFS_CONFIG);
    assign cfg_wr   = host_req.data_wr && cfg_sel;
    assign init_req = cfg_wr && host_req.wdata[`HMC_CFG_INIT_BIT];

    // Main supply sense synchroniser and rising-edge power-on detect
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            supply_meta_r <= 1'b0;
            supply_sync_r <= 1'b0;
            supply_prev_r <= 1'b0;
        end else begin
            supply_meta_r <= main_supply_sense;
            supply_sync_r <= supply_meta_r;
            supply_prev_r <= supply_sync_r;
        end
    end

    assign supply_por = supply_sync_r && !supply_prev_r;
    assign restore    = init_req || supply_por;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            init_pulse_r <= 1'b0;
        end else begin
            init_pulse_r <= restore;
        end
    end

    // Reset-pulse sequencer
    assign pulse_start = cfg_wr && !init_req
                      && host_req.wdata[`HMC_CFG_RSTPULSE_BIT]
                      && (pulse_state_r == hmc_pkg::HMC_PULSE_IDLE);
    assign pulse_done  = (pulse_state_r == hmc_pkg::HMC_PULSE_LOW)
                      && (pulse_cnt_r == CNT_W'(RSTPULSE_CYC - 1));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pulse_state_r <= hmc_pkg::HMC_PULSE_IDLE;
            pulse_cnt_r   <= '0;
            reset_out_n_r <= 1'b1;
        end else if (restore) begin
            pulse_state_r <= hmc_pkg::HMC_PULSE_IDLE;
            pulse_cnt_r   <= '0;
            reset_out_n_r <= 1'b1;
        end else begin
            case (pulse_state_r)
                hmc_pkg::HMC_PULSE_IDLE: begin
                    pulse_cnt_r <= '0;
                    if (pulse_start && reset_out_enable) begin
                        pulse_state_r <= hmc_pkg::HMC_PULSE_LOW;
                        reset_out_n_r <= 1'b0;
                    end
                end
                hmc_pkg::HMC_PULSE_LOW: begin
                    if (pulse_done) begin
                        pulse_state_r <= hmc_pkg::HMC_PULSE_IDLE;
                        reset_out_n_r <= 1'b1;
                    end else begin
                        pulse_cnt_r <= pulse_cnt_r + CNT_W'(1);
                    end
                end
                default: begin
                    pulse_state_r <= hmc_pkg::HMC_PULSE_IDLE;
                    reset_out_n_r <= 1'b1;
                end
            endcase
        end
    end

    // Configuration register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_r <= `HMC_CFG_RESET_VAL;
        end else if (restore) begin
            cfg_r <= `HMC_CFG_RESET_VAL;
        end else if (cfg_wr) begin
            // Reserved bits keep reset value; init bit never stored
            cfg_r <= (host_req.wdata & `HMC_CFG_WR_MASK)
                   | (`HMC_CFG_RESET_VAL & ~`HMC_CFG_WR_MASK);
            // Reset bit stays set only while a pulse runs
            cfg_r[`HMC_CFG_RSTPULSE_BIT] <= pulse_start
                                         && reset_out_enable;
        end else if (pulse_done) begin
            cfg_r[`HMC_CFG_RSTPULSE_BIT] <= 1'b0;
        end
    end

    // Status register 1: sticky limit flags, an event beats a clear
    always_comb begin
        status1_nxt = restore ? `HMC_ST1_RESET_VAL : status1_r;
        status1_nxt[0] = status1_nxt[0] | limit_evt.rail_2v5;
        status1_nxt[1] = status1_nxt[1] | limit_evt.core;
        status1_nxt[2] = status1_nxt[2] | limit_evt.rail_3v3;
        status1_nxt[3] = status1_nxt[3] | limit_evt.rail_5v;
        status1_nxt[4] = status1_nxt[4] | limit_evt.ambient_temp;
        status1_nxt = status1_nxt & `HMC_ST1_USED_MASK;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status1_r <= `HMC_ST1_RESET_VAL;
        end else begin
            status1_r <= status1_nxt;
        end
    end

    // Read decode on the stored index
    always_comb begin
        if (index_r == `HMC_OFS_MAKER_ID) begin
            rd_mux = `HMC_MAKER_ID_VAL;
        end else if (index_r == `HMC_OFS_STEP_VER) begin
            rd_mux = {`HMC_VERSION_VAL, `HMC_STEPPING_VAL};
        end else if (index_r == `HMC_OFS_CONFIG) begin
            rd_mux = cfg_r;
        end else if (index_r == `HMC_OFS_STATUS1) begin
            rd_mux = status1_r;
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data_r  <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= host_req.data_rd;
            if (host_req.data_rd) begin
                rd_data_r <= rd_mux;
            end
        end
    end

    assign reg_hit = (index_r == `HMC_OFS_MAKER_ID)
                  || (index_r == `HMC_OFS_STEP_VER)
                  || (index_r == `HMC_OFS_CONFIG)
                  || (index_r == `HMC_OFS_STATUS1);

    // Outputs
    assign rd_data                    = rd_data_r;
    assign rd_valid                   = rd_valid_r;
    assign monitor_run                = cfg_r[`HMC_CFG_START_BIT];
    assign low_power_hold             = !cfg_r[`HMC_CFG_START_BIT];
    assign low_power_mode             = low_power_hold
                                     && low_power_mode_sel;
    assign shared_pin_function_select = cfg_r[`HMC_CFG_PINSEL_BIT];
    assign init_pulse                 = init_pulse_r;
    assign reset_out_n                = reset_out_n_r;

endmodule : hmc_top

// [testbench/hmc_top_sva.sv]
// Checker for the monitor configuration and status registers.
// Assumes binding to hmc_top; sees only its ports.
`timescale 1ns/10ps
`include "hmc_defs.svh"
module hmc_top_sva #(
    parameter int unsigned RSTPULSE_CYC = 8
) (
    // Clock and reset
    input wire logic                   clock,
    input wire logic                   rst,
    // Host side
    input wire hmc_pkg::hmc_host_req_t host_req,
    input wire logic [7:0]             rd_data,
    input wire logic                   rd_valid,
    input wire logic                   reg_hit,
    // Controls
    input wire logic                   reset_out_enable,
    input wire logic                   low_power_mode_sel,
    input wire logic                   monitor_run,
    input wire logic                   low_power_hold,
    input wire logic                   low_power_mode,
    input wire logic                   shared_pin_function_select,
    input wire logic                   init_pulse,
    input wire logic                   reset_out_n
);
    logic [7:0]  idx_r;
    int unsigned low_cnt_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) idx_r <= 8'h00;
        else if (host_req.index_wr) idx_r <= host_req.wdata;
    end
    // Length of the current low phase on the reset pin
    always_ff @(posedge clock or posedge rst) begin
        if (rst) low_cnt_r <= 0;
        else if (!reset_out_n) low_cnt_r <= low_cnt_r + 1;
        else low_cnt_r <= 0;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence cfg_wr_s;
        host_req.data_wr && idx_r == `HMC_OFS_CONFIG;
    endsequence
    rd_answer_a: assert property (
        rd_valid == $past(host_req.data_rd)) else $error("bad rd_valid");
    index_hit_a: assert property (host_req.index_wr |=>
        reg_hit == ($past(host_req.wdata) inside {[8'h3E:8'h41]}))
        else $error("bad reg_hit");
    maker_id_a: assert property (
        host_req.data_rd && idx_r == `HMC_OFS_MAKER_ID |=>
        rd_data == `HMC_MAKER_ID_VAL) else $error("bad maker id");
    step_ver_a: assert property (
        host_req.data_rd && idx_r == `HMC_OFS_STEP_VER |=>
        rd_data == {`HMC_VERSION_VAL, `HMC_STEPPING_VAL})
        else $error("bad stepping");
    low_power_a: assert property (
        low_power_hold == !monitor_run &&
        low_power_mode == (low_power_hold && low_power_mode_sel))
        else $error("bad low power");
    cfg_store_a: assert property (
        cfg_wr_s ##0 !host_req.wdata[7] |=>
        monitor_run == $past(host_req.wdata[0]) &&
        shared_pin_function_select == $past(host_req.wdata[5]))
        else $error("config not stored");
    pulse_start_a: assert property (
        cfg_wr_s ##0 (host_req.wdata[4] && !host_req.wdata[7] &&
        reset_out_enable && reset_out_n) |=> !reset_out_n)
        else $error("reset pulse not started");
    pulse_len_a: assert property (
        $rose(reset_out_n) && !init_pulse |-> low_cnt_r == RSTPULSE_CYC)
        else $error("bad reset pulse length");
    init_cfg_a: assert property (
        cfg_wr_s ##0 host_req.wdata[7] |=> init_pulse && reset_out_n &&
        !monitor_run && !shared_pin_function_select)
        else $error("init did not restore");
endmodule : hmc_top_sva
bind hmc_top hmc_top_sva #(.RSTPULSE_CYC(RSTPULSE_CYC)) i_sva (
    .clock(clock), .rst(rst), .host_req(host_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .reg_hit(reg_hit),
    .reset_out_enable(reset_out_enable),
    .low_power_mode_sel(low_power_mode_sel), .monitor_run(monitor_run),
    .low_power_hold(low_power_hold), .low_power_mode(low_power_mode),
    .shared_pin_function_select(shared_pin_function_select),
    .init_pulse(init_pulse), .reset_out_n(reset_out_n));

// [testbench/hmc_host_model.sv]
// Host model driving index and data strobes into the register bank.
// Assumes one clock; each strobe is taken at a single rising edge.
`timescale 1ns/10ps
module hmc_host_model (
    // Clock
    input  wire logic              clock,
    // Host access
    output hmc_pkg::hmc_host_req_t host_req
);
    initial host_req = '0;
    // Strobe held over one edge, then data scrambled
    task automatic put(input logic [2:0] kind, input logic [7:0] d);
        @(posedge clock);
        #1 host_req = {kind, d};
        @(posedge clock);
        #1 host_req = {3'b000, ~d};
    endtask : put
endmodule : hmc_host_model

// [testbench/hmc_top_bench.sv]
// Self-checking bench for the monitor configuration and status registers.
// Assumes hmc_top with a shortened reset pulse and the host model.
`timescale 1ns/10ps
`include "hmc_defs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR %0t got %h exp %h", $time, a, b); end end
module hmc_top_bench;
    localparam int unsigned PULSE = 8;
    logic clock, rst, main_supply_sense, reset_out_enable;
    logic low_power_mode_sel, rd_valid, reg_hit, monitor_run;
    logic low_power_hold, low_power_mode, shared_pin_function_select;
    logic init_pulse, reset_out_n;
    logic [7:0]              rd_data, e;
    logic [4:0]              r1, r2;
    hmc_pkg::hmc_limit_evt_t limit_evt;
    hmc_pkg::hmc_host_req_t  host_req;
    logic [7:0]              exp_q[$];
    int                      bad_count, cmp_count, n;
    initial begin
        clock = 0;
        forever #20 clock = ~clock;
    end
    hmc_host_model i_host (.clock(clock), .host_req(host_req));
    hmc_top #(.RSTPULSE_CYC(PULSE)) i_dut (.clock(clock), .rst(rst),
        .host_req(host_req), .rd_data(rd_data), .rd_valid(rd_valid),
        .reg_hit(reg_hit), .main_supply_sense(main_supply_sense),
        .limit_evt(limit_evt), .reset_out_enable(reset_out_enable),
        .low_power_mode_sel(low_power_mode_sel), .monitor_run(monitor_run),
        .low_power_hold(low_power_hold), .low_power_mode(low_power_mode),
        .shared_pin_function_select(shared_pin_function_select),
        .init_pulse(init_pulse), .reset_out_n(reset_out_n));
    always @(posedge clock) begin
        if (rd_valid === 1'b1) begin
            e = exp_q.pop_front();
            `CHK(rd_data, e)
        end
    end
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        i_host.put(3'b100, a);
        i_host.put(3'b001, 8'h00);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.put(3'b100, a);
        i_host.put(3'b010, d);
    endtask : wr
    task automatic final_report;
        $display("Checks %0d, errors %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    initial begin
        rst = 1;
        {main_supply_sense, reset_out_enable, low_power_mode_sel} = 3'h0;
        limit_evt = '0;
        bad_count = 0;
        cmp_count = 0;
        void'($urandom(32'h3583));
        repeat (2) @(posedge clock);
        #1 rst = 0;
        rd(8'h3E, `HMC_MAKER_ID_VAL);
        rd(8'h3F, {`HMC_VERSION_VAL, `HMC_STEPPING_VAL});
        rd(8'h40, `HMC_CFG_RESET_VAL);
        rd(8'h41, `HMC_ST1_RESET_VAL);
        rd(8'h10, 8'h00);
        wr(8'h3E, 8'h00);
        rd(8'h3E, `HMC_MAKER_ID_VAL);
        low_power_mode_sel = 1'($urandom);
        // No limit registers in this block, so start may be set at once
        wr(8'h40, 8'h6F);
        rd(8'h40, 8'h29);
        `CHK(monitor_run, 1'b1)
        `CHK(shared_pin_function_select, 1'b1)
        wr(8'h40, 8'h28);
        `CHK(low_power_mode, low_power_mode_sel)
        reset_out_enable = 1;
        wr(8'h40, 8'h11);
        `CHK(reset_out_n, 1'b0)
        rd(8'h40, 8'h19);
        // Look just after each edge so the pin has settled
        for (n = 0; reset_out_n === 1'b0 && n < 20; n++) begin
            @(posedge clock);
            #1;
        end
        `CHK(n, PULSE - 4)
        rd(8'h40, 8'h09);
        reset_out_enable = 0;
        wr(8'h40, 8'h30);
        `CHK(reset_out_n, 1'b1)
        rd(8'h40, 8'h28);
        r1 = 5'($urandom);
        r2 = 5'($urandom);
        @(posedge clock);
        #1 limit_evt = r1;
        @(posedge clock);
        #1 limit_evt = r2;
        @(posedge clock);
        #1 limit_evt = '0;
        rd(8'h41, {3'b000, r1 | r2});
        wr(8'h41, 8'hFF);
        rd(8'h41, {3'b000, r1 | r2});
        wr(8'h40, 8'h81);
        `CHK(init_pulse, 1'b1)
        rd(8'h40, 8'h08);
        rd(8'h41, 8'h00);
        wr(8'h40, 8'h01);
        #40 limit_evt = 5'h1F;
        #40 limit_evt = '0;
        main_supply_sense = 1;
        repeat (4) @(posedge clock);
        rd(8'h41, 8'h00);
        rd(8'h40, 8'h08);
        for (n = 0; exp_q.size() != 0 && n < 10; n++) @(posedge clock);
        if (exp_q.size() != 0) bad_count++;
        final_report();
    end
endmodule : hmc_top_bench
